/* rtl/rgc_regs.vh */
// rgc_regs.vh: offsets, bit positions, reset values and timing counts
// assumes: included by the gain control design files only
`ifndef RGC_REGS_VH
`define RGC_REGS_VH

// serial register offsets
`define RGC_ADDR_RX_GAIN     7'h09
`define RGC_ADDR_TX_GAIN     7'h0A
`define RGC_ADDR_GAIN_SRC    7'h0B
`define RGC_ADDR_TX_ROUTE    7'h0E

// field positions
`define RGC_CODE_MSB         5
`define RGC_UPD_EN_BIT       6
`define RGC_SRC_TXSEL_BIT    6
`define RGC_SRC_RXSEL_BIT    5
`define RGC_SRC_SWSTB_BIT    3
`define RGC_SRC_NIBEN_BIT    2
`define RGC_SRC_MAP3_BIT     1
`define RGC_ROUTE_CONV_BIT   0

// reset values and limits
`define RGC_RX_GAIN_RST      6'h00
`define RGC_TX_GAIN_RST      6'h00
`define RGC_ROUTE_RST        8'h00
`define RGC_RX_GAIN_MAX      6'h3C

// serial frame: read flag, 7-bit offset, 8-bit data
`define RGC_FRAME_BITS       5'h10
`define RGC_HDR_LAST_BIT     5'h07
`define RGC_DATA_LAST_BIT    5'h0F

// port clock half period
`define RGC_CLK_FREQ_MHZ     20
`define RGC_PORT_HALF_NS     200
`define RGC_PORT_HALF_CYC    ((`RGC_PORT_HALF_NS * `RGC_CLK_FREQ_MHZ + 999) / 1000)

`endif

/* rtl/rgc_sync.v */
// rgc_sync.v: two-flop synchroniser for a bus of independent levels
// assumes: each bit is a slow level or is sampled only after settling
`timescale 1ns/10ps
`default_nettype none

module rgc_sync #(
  parameter WIDTH = 1
) (
  // clock
  input  wire             clk,
  // levels
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut_r
);

  reg [WIDTH-1:0] meta_r;

  // no reset: straps must reach the strap defaults while reset is held
  always @(posedge clk) begin
    meta_r    <= asyncIn;
    syncOut_r <= meta_r;
  end

endmodule

`default_nettype wire

/* rtl/rgc_gain_control.v */
// rgc_gain_control.v: receive and transmit gain code registers and loaders
// assumes: all pins asynchronous to clk; serial clock well below clk / 4
//
// Operation
// R01 - six-bit receive code, -12 to +48 dB
// R02 - receive code split over three stages
// R03 - receive gain resets to minimum
// R04 - receive_gain_code code needs bit 6 set
// R05 - receive gain has three load sources
// R06 - full duplex nibble load on strobe, sync low
// R07 - host holds strobe, sync and code stable
// R08 - strobe low sends nibbles to interpolator
// R09 - gain_source_select bit 2 enables nibble gain load
// R10 - gain_source_select bit 3 is software strobe
// R11 - gain port loads without any qualifier
// R12 - bits 5/6 route gain port rx/tx
// R13 - gain port works both modes, half default
// R14 - host deselects rx before selecting tx
// R15 - three-bit code from gain port 5:3
// R16 - three-bit code table fixed gains
// R17 - gain_source_select bit 1 selects three-bit mapping
// R18 - transmit code is 0.5 dB attenuation
// R19 - transmit_output_route bit 0 uses low four bits
// R20 - transmit_gain_code code needs bit 6 set
// R21 - transmit resets minimum attenuation, port off
// R22 - mode pin high selects full duplex
// R23 - full duplex drives port clock out
// R24 - priority nibble, gain port, serial
// R25 - bits 5 and 6 load both
`timescale 1ns/10ps
`default_nettype none
`include "rgc_regs.vh"

module rgc_gain_control #(
  parameter PORT_HALF_CYC = `RGC_PORT_HALF_CYC
) (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // straps
  input  wire       modePin,
  input  wire       configPin,
  input  wire       portClockNegEdge,
  // serial control port
  input  wire       serialClk,
  input  wire       serialEnable_n,
  input  wire       serialDataIn,
  output reg        serialDataOut_r,
  output reg        serialDataOe_r,
  // nibble transmit port
  input  wire [5:0] txNibble,
  input  wire       gainStrobe,
  input  wire       transmitNibbleSync,
  output reg        portClockOut_r,
  output reg  [5:0] interpNibble_r,
  output reg        interpValid_r,
  // dedicated gain port
  input  wire [5:0] gainPort,
  // receive gain amp stage controls
  output reg  [5:0] receiveGainAmp_r,
  output reg  [1:0] rxStageCoarse_r,
  output reg  [1:0] rxStageMid_r,
  output reg  [1:0] rxStageFine_r,
  // transmit attenuator controls
  output reg  [5:0] transmitAttenuator_r,
  output reg  [3:0] transmitConverter_r,
  output reg  [5:0] currentAmplifier_r,
  output reg        currentAmpEnable_r
);

  // synchronised pins
  wire [19:0] pinsSync;
  wire        modeS;
  wire        configS;
  wire        edgeSelS;
  wire        sclkS;
  wire        senS_n;
  wire        sdiS;
  wire [5:0]  nibbleS;
  wire        strobeS;
  wire        nibSyncS;
  wire [5:0]  gainPortS;

  // pins flow through the chain even while reset is held
  rgc_sync #(
    .WIDTH(20)
  ) uSync (
    .clk      (clk),
    .asyncIn  ({modePin, configPin, portClockNegEdge,
                serialClk, serialEnable_n, serialDataIn,
                txNibble, gainStrobe, transmitNibbleSync, gainPort}),
    .syncOut_r(pinsSync)
  );

  // unpack in the order packed above
  assign modeS     = pinsSync[19];
  assign configS   = pinsSync[18];
  assign edgeSelS  = pinsSync[17];
  assign sclkS     = pinsSync[16];
  assign senS_n    = pinsSync[15];
  assign sdiS      = pinsSync[14];
  assign nibbleS   = pinsSync[13:8];
  assign strobeS   = pinsSync[7];
  assign nibSyncS  = pinsSync[6];
  assign gainPortS = pinsSync[5:0];

  // clamp to the +48 dB top code
  function [5:0] clampCode;
    input [5:0] code;
    begin
      clampCode = (code > `RGC_RX_GAIN_MAX) ? `RGC_RX_GAIN_MAX : code; // R01
    end
  endfunction

  // three-bit legacy mapping to six-bit code
  function [5:0] map3;
    input [2:0] code;
    begin
      case (code)
        3'h0:    map3 = 6'h00; // R16
        3'h1:    map3 = 6'h00; // R16
        3'h2:    map3 = 6'h08;
        3'h3:    map3 = 6'h10;
        3'h4:    map3 = 6'h18;
        3'h5:    map3 = 6'h20;
        3'h6:    map3 = 6'h28;
        3'h7:    map3 = 6'h30;
        default: map3 = 6'h00;
      endcase
    end
  endfunction

  // register state
  reg [5:0] rxGain_nxt;
  reg [5:0] txGain_nxt;
  reg       rxSerialEn_r;
  reg       txSerialEn_r;
  reg [7:0] gainSource_r;
  reg [7:0] txRoute_r;

  // serial port state
  reg        sclkPrev_r;
  reg [15:0] shift_r;
  reg [4:0]  bitCnt_r;
  reg        readMode_r;
  reg [7:0]  readData_r;
  reg        wrStrobe_r;
  reg [6:0]  wrAddr_r;
  reg [7:0]  wrData_r;
  wire       sclkRise;
  wire       sclkFall;
  wire [15:0] shiftIn;

  // port clock state
  reg [15:0] portCnt_r;
  wire       portToggle;
  wire       portRiseEv;
  wire       portFallEv;
  wire       nibbleEdge;
  wire       strobeActive;
  wire       nibbleLoad;

  // register readback
  function [7:0] regRead;
    input [6:0] addr;
    begin
      case (addr)
        `RGC_ADDR_RX_GAIN:  regRead = rxSerialEn_r ?
                              {2'b01, receiveGainAmp_r} : 8'h00; // R04
        `RGC_ADDR_TX_GAIN:  regRead = txSerialEn_r ?
                              {2'b01, transmitAttenuator_r} : 8'h00; // R20
        `RGC_ADDR_GAIN_SRC: regRead = gainSource_r;
        `RGC_ADDR_TX_ROUTE: regRead = txRoute_r;
        default:            regRead = 8'h00;
      endcase
    end
  endfunction

  // serial frame engine
  assign sclkRise = sclkS & ~sclkPrev_r;
  assign sclkFall = ~sclkS & sclkPrev_r;
  assign shiftIn  = {shift_r[14:0], sdiS};

  always @(posedge clk) begin
    if (!reset_n) begin
      sclkPrev_r      <= 1'b0;
      shift_r         <= 16'h0000;
      bitCnt_r        <= 5'h00;
      readMode_r      <= 1'b0;
      readData_r      <= 8'h00;
      wrStrobe_r      <= 1'b0;
      wrAddr_r        <= 7'h00;
      wrData_r        <= 8'h00;
      serialDataOut_r <= 1'b0;
      serialDataOe_r  <= 1'b0;
    end else begin
      sclkPrev_r <= sclkS;
      wrStrobe_r <= 1'b0;
      if (senS_n) begin
        bitCnt_r       <= 5'h00;
        readMode_r     <= 1'b0;
        serialDataOe_r <= 1'b0;
      end else begin
        if (sclkRise && bitCnt_r < `RGC_FRAME_BITS) begin
          shift_r  <= shiftIn;
          bitCnt_r <= bitCnt_r + 5'h01;
          if (bitCnt_r == `RGC_HDR_LAST_BIT && shiftIn[7]) begin
            readMode_r <= 1'b1;
            readData_r <= regRead(shiftIn[6:0]);
          end
          if (bitCnt_r == `RGC_DATA_LAST_BIT && !readMode_r) begin
            wrStrobe_r <= 1'b1;
            wrAddr_r   <= shiftIn[14:8];
            wrData_r   <= shiftIn[7:0];
          end
        end
        if (sclkFall && readMode_r) begin
          serialDataOe_r  <= (bitCnt_r < `RGC_FRAME_BITS);
          serialDataOut_r <= readData_r[7];
          readData_r      <= {readData_r[6:0], 1'b0};
        end
      end
    end
  end

  // port clock divider, full duplex only
  assign portToggle = modeS && (portCnt_r == PORT_HALF_CYC - 1);
  assign portRiseEv = portToggle & ~portClockOut_r;
  assign portFallEv = portToggle & portClockOut_r;

  always @(posedge clk) begin
    if (!reset_n) begin
      portCnt_r      <= 16'h0000;
      portClockOut_r <= 1'b0;
    end else if (!modeS) begin
      portCnt_r      <= 16'h0000;
      portClockOut_r <= 1'b0; // R22
    end else if (portToggle) begin
      portCnt_r      <= 16'h0000;
      portClockOut_r <= ~portClockOut_r; // R23
    end else begin
      portCnt_r <= portCnt_r + 16'h0001;
    end
  end

  // nibble port qualifiers
  assign nibbleEdge   = edgeSelS ? portFallEv : portRiseEv; // R06
  assign strobeActive = strobeS | gainSource_r[`RGC_SRC_SWSTB_BIT]; // R10
  assign nibbleLoad   = modeS & gainSource_r[`RGC_SRC_NIBEN_BIT] & nibbleEdge
                        & strobeActive & ~nibSyncS; // R09

  // nibble routing to the interpolator
  always @(posedge clk) begin
    if (!reset_n) begin
      interpNibble_r <= 6'h00;
      interpValid_r  <= 1'b0;
    end else begin
      interpValid_r <= 1'b0;
      if (modeS && nibbleEdge && !strobeActive) begin
        interpNibble_r <= nibbleS; // R08
        interpValid_r  <= 1'b1;
      end
    end
  end

  // gain load priority: later assignment wins
  always @* begin
    rxGain_nxt = receiveGainAmp_r;
    txGain_nxt = transmitAttenuator_r;
    if (wrStrobe_r && wrData_r[`RGC_UPD_EN_BIT]) begin
      if (wrAddr_r == `RGC_ADDR_RX_GAIN)
        rxGain_nxt = clampCode(wrData_r[5:0]); // R04
      if (wrAddr_r == `RGC_ADDR_TX_GAIN)
        txGain_nxt = wrData_r[5:0]; // R20
    end
    if (gainSource_r[`RGC_SRC_RXSEL_BIT]) begin
      if (gainSource_r[`RGC_SRC_MAP3_BIT])
        rxGain_nxt = map3(gainPortS[5:3]); // R15
      else
        rxGain_nxt = clampCode(gainPortS); // R11
    end
    if (gainSource_r[`RGC_SRC_TXSEL_BIT])
      txGain_nxt = gainPortS; // R25
    if (nibbleLoad)
      rxGain_nxt = clampCode(nibbleS); // R24
  end

  // gain and configuration registers
  always @(posedge clk) begin
    if (!reset_n) begin
      receiveGainAmp_r     <= `RGC_RX_GAIN_RST; // R03
      transmitAttenuator_r <= `RGC_TX_GAIN_RST; // R21
      rxSerialEn_r         <= 1'b0;
      txSerialEn_r         <= 1'b0;
      txRoute_r            <= `RGC_ROUTE_RST;
      // strap defaults: gain port rx in half duplex, nibble load in full
      gainSource_r         <= {2'b00, ~modeS, 2'b00, modeS,
                               ~modeS & configS, 1'b0}; // R13
    end else begin
      receiveGainAmp_r     <= rxGain_nxt; // R05
      transmitAttenuator_r <= txGain_nxt;
      if (wrStrobe_r) begin
        case (wrAddr_r)
          `RGC_ADDR_RX_GAIN:  rxSerialEn_r <= wrData_r[`RGC_UPD_EN_BIT];
          `RGC_ADDR_TX_GAIN:  txSerialEn_r <= wrData_r[`RGC_UPD_EN_BIT];
          `RGC_ADDR_GAIN_SRC: gainSource_r <= wrData_r; // R12
          `RGC_ADDR_TX_ROUTE: txRoute_r    <= wrData_r;
          default:            txRoute_r    <= txRoute_r;
        endcase
      end
    end
  end

  // stage split and transmit routing
  always @(posedge clk) begin
    if (!reset_n) begin
      rxStageCoarse_r     <= 2'b00;
      rxStageMid_r        <= 2'b00;
      rxStageFine_r       <= 2'b00;
      transmitConverter_r <= 4'h0;
      currentAmplifier_r  <= 6'h00;
      currentAmpEnable_r  <= 1'b0;
    end else begin
      rxStageCoarse_r <= receiveGainAmp_r[5:4]; // R02
      rxStageMid_r    <= receiveGainAmp_r[3:2];
      rxStageFine_r   <= receiveGainAmp_r[1:0];
      if (txRoute_r[`RGC_ROUTE_CONV_BIT]) begin
        transmitConverter_r <= transmitAttenuator_r[3:0]; // R19
        currentAmplifier_r  <= 6'h00;
        currentAmpEnable_r  <= 1'b0;
      end else begin
        transmitConverter_r <= 4'h0;
        currentAmplifier_r  <= transmitAttenuator_r; // R18
        currentAmpEnable_r  <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* tb/rgc_checker.sv */
// rgc_checker.sv: assertions on the gain control ports
// assumes: bound onto rgc_gain_control
`timescale 1ns/10ps
`default_nettype none
module rgc_checker #(
  parameter PORT_HALF_CYC = 4
) (
  // clock, reset, strap
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       modePin,
  // outputs
  input wire logic       portClockOut_r,
  input wire logic       interpValid_r,
  input wire logic [5:0] receiveGainAmp_r,
  input wire logic [5:0] transmitAttenuator_r,
  input wire logic [3:0] transmitConverter_r,
  input wire logic [5:0] currentAmplifier_r,
  input wire logic       currentAmpEnable_r
);
  logic [7:0] halfCnt_r;
  logic       seen_r;
  logic       prevPc_r;
  wire        pcMove = portClockOut_r != prevPc_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // cycles since the port clock moved
  always @(posedge clk) begin
    prevPc_r  <= portClockOut_r;
    halfCnt_r <= (!reset_n || pcMove) ? 8'h00 : halfCnt_r + 8'h01;
    seen_r    <= reset_n && (seen_r || pcMove);
  end
  property p_rxMax;
    receiveGainAmp_r <= 6'h3C;
  endproperty
  a_rxMax: assert property (p_rxMax) else $error("rx over max");
  property p_rxRst;
    $rose(reset_n) |-> receiveGainAmp_r == 6'h00;
  endproperty
  a_rxRst: assert property (p_rxRst) else $error("rx reset");
  property p_txRst;
    $rose(reset_n) |-> transmitAttenuator_r == 6'h00 && currentAmplifier_r == 6'h00;
  endproperty
  a_txRst: assert property (p_txRst) else $error("tx reset");
  property p_conv;
    !currentAmpEnable_r && !$past(currentAmpEnable_r) && $stable(transmitAttenuator_r)
      |-> transmitConverter_r == transmitAttenuator_r[3:0];
  endproperty
  a_conv: assert property (p_conv) else $error("converter code");
  property p_amp;
    currentAmpEnable_r && $past(currentAmpEnable_r) && $stable(transmitAttenuator_r)
      |-> currentAmplifier_r == transmitAttenuator_r && transmitConverter_r == 4'h0;
  endproperty
  a_amp: assert property (p_amp) else $error("amplifier code");
  property p_half;
    !modePin [*6] |-> !portClockOut_r && !interpValid_r;
  endproperty
  a_half: assert property (p_half) else $error("half duplex port");
  property p_div;
    seen_r && modePin && pcMove |-> halfCnt_r == PORT_HALF_CYC - 1;
  endproperty
  a_div: assert property (p_div) else $error("port clock rate");
  property p_pulse;
    interpValid_r |=> !interpValid_r;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
endmodule
bind rgc_gain_control rgc_checker #(
  .PORT_HALF_CYC(PORT_HALF_CYC)
) chk_u (
  .clk(clk), .reset_n(reset_n), .modePin(modePin), .portClockOut_r(portClockOut_r),
  .interpValid_r(interpValid_r), .receiveGainAmp_r(receiveGainAmp_r),
  .transmitAttenuator_r(transmitAttenuator_r), .transmitConverter_r(transmitConverter_r),
  .currentAmplifier_r(currentAmplifier_r), .currentAmpEnable_r(currentAmpEnable_r)
);
`default_nettype wire

/* tb/rgc_asic_model.sv */
// rgc_asic_model.sv: baseband side of the nibble port
// assumes: port clock comes from the block; requests set by the bench
`timescale 1ns/10ps
`default_nettype none
module rgc_asic_model (
  // port clock
  input  wire logic       portClockOut_r,
  input  wire logic       portClockNegEdge,
  // requests
  input  wire logic [5:0] reqCode,
  input  wire logic       reqStrobe,
  input  wire logic       reqSync,
  // pins
  output var  logic [5:0] txNibble,
  output var  logic       gainStrobe,
  output var  logic       transmitNibbleSync
);
  wire sampEdge = portClockOut_r ^ portClockNegEdge;
  initial begin
    txNibble = 6'h00;
    gainStrobe = 1'b0;
    transmitNibbleSync = 1'b1;
  end
  // change at the sampling edge, hold a full period
  always @(posedge sampEdge) begin
    txNibble           <= reqCode;
    gainStrobe         <= reqStrobe;
    transmitNibbleSync <= reqSync;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// tb_top.sv: self-checking bench for rgc_gain_control
// assumes: asic model on the nibble port, bench on serial and gain port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errCount++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        modePin = 1'b0;
  logic        cfgPin = 1'b1;
  logic        rdOe = 1'b0;
  wire  [5:0]  iNib;
  wire  [5:0]  rxStg;
  wire         sOe;
  logic        negEdge = 1'b0;
  logic        sClk = 1'b0;
  logic        sEn_n = 1'b1;
  logic        sDin = 1'b0;
  logic [5:0]  gainPort = 6'h00;
  logic [5:0]  reqCode = 6'h00;
  logic        reqStb = 1'b0;
  logic        reqSync = 1'b1;
  wire  [5:0]  nib;
  wire         stb;
  wire         nibSync;
  wire         sDout;
  wire         pClk;
  wire         iValid;
  wire  [5:0]  rxGain;
  wire  [5:0]  txGain;
  wire  [3:0]  txConv;
  wire         ampEn;
  integer      errCount = 0;
  integer      checked = 0;
  integer      pulses = 0;
  integer      i;
  logic [31:0] seed = 32'h00015DDD;
  logic [7:0]  rd;
  logic [5:0]  v;
  logic [5:0]  keep;
  always #25 clk = ~clk;
  always @(posedge clk) if (iValid === 1'b1) pulses <= pulses + 1;
  rgc_gain_control dut_u (
    .clk(clk), .reset_n(reset_n), .modePin(modePin), .configPin(cfgPin),
    .portClockNegEdge(negEdge), .serialClk(sClk), .serialEnable_n(sEn_n),
    .serialDataIn(sDin), .serialDataOut_r(sDout), .serialDataOe_r(sOe), .txNibble(nib),
    .gainStrobe(stb), .transmitNibbleSync(nibSync), .portClockOut_r(pClk),
    .interpNibble_r(iNib), .interpValid_r(iValid), .gainPort(gainPort),
    .receiveGainAmp_r(rxGain), .rxStageCoarse_r(rxStg[5:4]),
    .rxStageMid_r(rxStg[3:2]), .rxStageFine_r(rxStg[1:0]),
    .transmitAttenuator_r(txGain), .transmitConverter_r(txConv),
    .currentAmplifier_r(), .currentAmpEnable_r(ampEn)
  );
  rgc_asic_model asic_u (
    .portClockOut_r(pClk), .portClockNegEdge(negEdge), .reqCode(reqCode),
    .reqStrobe(reqStb), .reqSync(reqSync), .txNibble(nib), .gainStrobe(stb),
    .transmitNibbleSync(nibSync)
  );
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [5:0] map3(input [2:0] c);
    map3 = (c < 3'h2) ? 6'h00 : {c - 3'h1, 3'h0};
  endfunction
  task automatic cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rnd(output logic [5:0] r);
    seed = lfsr(seed);
    r = (seed[5:0] > 6'h3C) ? 6'h3C : seed[5:0];
  endtask
  task automatic doReset(input logic m, input logic c);
    reset_n <= 1'b0;
    modePin <= m;
    cfgPin <= c;
    negEdge <= seed[3];
    cyc(4);
    reset_n <= 1'b1;
    cyc(4);
  endtask
  // read flag, offset, data; 400 ns serial clock only inside the frame
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rw, a, d};
    rdOe = 1'b1;
    sEn_n <= 1'b0;
    for (int k = 15; k >= 0; k--) begin
      sDin <= f[k];
      sClk <= 1'b0;
      cyc(4);
      sClk <= 1'b1;
      cyc(3);
      @(negedge clk) if (k < 8) begin
        rd[k] = sDout;
        rdOe = rdOe & sOe;
      end
      @(posedge clk);
    end
    sClk <= 1'b0;
    sEn_n <= 1'b1;
    cyc(8);
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #3000000;
    errCount++;
    final_report;
  end
  initial begin
    doReset(1'b0, 1'b1);
    `CHK(rxGain, 6'h00)
    `CHK(txGain, 6'h00)
    frame(1'b1, 7'h0B, 8'h00);
    `CHK(rd, 8'h22)
    frame(1'b1, 7'h0D, 8'h00);
    `CHK(rd, 8'h00)
    for (i = 0; i < 8; i++) begin
      rnd(v);
      gainPort <= {i[2:0], v[2:0]};
      cyc(6);
      `CHK(rxGain, map3(i[2:0]))
    end
    frame(1'b0, 7'h0B, 8'h20);
    for (i = 0; i < 6; i++) begin
      rnd(keep);
      gainPort <= keep;
      cyc(6);
      `CHK(rxGain, keep)
    end
    `CHK(rxStg, keep)
    frame(1'b0, 7'h0B, 8'h00);
    rnd(v);
    gainPort <= v;
    cyc(6);
    `CHK({rxGain, txGain}, {keep, 6'h00})
    frame(1'b0, 7'h0B, 8'h40);
    `CHK({txGain, rxGain}, {v, keep})
    frame(1'b0, 7'h0B, 8'h60);
    rnd(v);
    gainPort <= v;
    cyc(6);
    `CHK({rxGain, txGain}, {v, v})
    frame(1'b0, 7'h0B, 8'h00);
    frame(1'b0, 7'h0A, {2'b01, keep});
    `CHK(txGain, keep)
    frame(1'b1, 7'h0A, 8'h00);
    `CHK(rd, {2'b01, keep})
    frame(1'b0, 7'h09, 8'h15);
    `CHK(rxGain, v)
    frame(1'b0, 7'h09, 8'h7F);
    `CHK(rxGain, 6'h3C)
    frame(1'b1, 7'h09, 8'h00);
    `CHK(rd, 8'h7C)
    `CHK({rdOe, sOe}, 2'b10)
    frame(1'b0, 7'h0E, 8'h01);
    `CHK({ampEn, txConv}, {1'b0, keep[3:0]})
    frame(1'b0, 7'h0E, 8'h00);
    `CHK(ampEn, 1'b1)
    $display("half duplex done");
    doReset(1'b1, 1'b1);
    `CHK(rxGain, 6'h00)
    frame(1'b1, 7'h0B, 8'h00);
    `CHK(rd, 8'h04)
    rnd(v);
    reqCode <= v;
    reqStb <= 1'b1;
    reqSync <= 1'b0;
    cyc(30);
    `CHK(rxGain, v)
    reqCode <= {1'b0, ~v[4:0]};
    reqSync <= 1'b1;
    cyc(30);
    `CHK(rxGain, v)
    i = pulses;
    reqStb <= 1'b0;
    reqSync <= 1'b0;
    cyc(30);
    `CHK({rxGain, pulses > i}, {v, 1'b1})
    `CHK(iNib, {1'b0, ~v[4:0]})
    frame(1'b0, 7'h0B, 8'h0C);
    cyc(30);
    `CHK(rxGain, {1'b0, ~v[4:0]})
    frame(1'b0, 7'h0B, 8'h08);
    reqCode <= v;
    cyc(30);
    `CHK(rxGain, {1'b0, ~v[4:0]})
    $display("full duplex done");
    doReset(1'b0, 1'b0);
    frame(1'b1, 7'h0B, 8'h00);
    `CHK(rd, 8'h20)
    $display("config strap done");
    final_report;
  end
endmodule
`default_nettype wire
